/* File: logic/sbtc_top.sv */
`timescale 1ns/1ps
module sbtc_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_clock_pin,
  input wire logic osc_in_pin,
  input wire logic [1:0] port_c_pin_in,
  input wire logic compare_unit_reset,
  input wire logic sleep_mode,
  output logic osc_enable_out,
  output logic [1:0] port_c_input_force,
  output logic overflow_pulse
);
  logic [7:0] ctrl_q; // timer_control
  logic [7:0] low_q; // count_low_byte
  logic [7:0] high_q; // live high byte
  logic [7:0] hbuf_q; // count_high_buffer
  logic ovf_flag_q; // overflow_flag
  logic [1:0] port_dir_q; // port_c_direction bits 1:0
  logic [2:0] pre_q; // prescaler count
  logic [1:0] icyc_q; // instruction cycle divider
  logic [4:0] aw_q; // held write address
  logic aw_have_q;
  logic [31:0] w_q; // held write data
  logic [3:0] ws_q;
  logic w_have_q;
  logic osc_en_q;
  logic [1:0] force_q;
  logic ovf_q;
  sbtc_pkg::sbtc_mode_e mode;
  logic ext_src; // raw external source
  logic ext_rise_sync; // synchronised edge
  logic ext_last_q; // raw edge history for bypass path
  logic src_tick; // one source event
  logic pre_tick; // prescaled event
  logic [2:0] pre_last;
  logic wr_fire;
  logic rd_fire;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic wr_flags;
  logic wr_port;
  logic rd_low;
  logic [15:0] cnt;
  logic roll;
  logic [7:0] rd_byte;

  // crystal replaces the pin when enabled
  assign ext_src = ctrl_q[sbtc_pkg::BIT_OSC_EN] ? osc_in_pin : ext_count_clock_pin;

  sbtc_edge_sync u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(ext_src),
    .rise(ext_rise_sync)
  );

  // mode decode; sync bit ignored for internal source
  always_comb
  begin
    if (!ctrl_q[sbtc_pkg::BIT_CLK_SEL])
      mode = sbtc_pkg::SBTC_TIMER;
    else if (ctrl_q[sbtc_pkg::BIT_SYNC_BYP])
      mode = sbtc_pkg::SBTC_ASYNC_CNT;
    else
      mode = sbtc_pkg::SBTC_SYNC_CNT;
  end

  // bypass path: with one clock, edges are seen straight off the input
  // limitation: input is treated as synchronous, so bypass only trims latency
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_last_q <= 1'b0;
    else
      ext_last_q <= ext_src;
  end

  // instruction clock = system clock / 4
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      icyc_q <= 2'h0;
    else
      icyc_q <= icyc_q + 2'h1;
  end

  always_comb
  begin
    unique case (mode)
      sbtc_pkg::SBTC_TIMER: src_tick = (icyc_q == sbtc_pkg::INT_DIV_LAST);
      sbtc_pkg::SBTC_SYNC_CNT: src_tick = ext_rise_sync;
      sbtc_pkg::SBTC_ASYNC_CNT: src_tick = ext_src & ~ext_last_q;
    endcase
  end

  // prescale select: last count value before a tick passes
  always_comb
  begin
    unique case (ctrl_q[sbtc_pkg::BIT_DIV_HI:sbtc_pkg::BIT_DIV_LO])
      2'h3: pre_last = 3'h7;
      2'h2: pre_last = 3'h3;
      2'h1: pre_last = 3'h1;
      2'h0: pre_last = 3'h0;
    endcase
  end
  assign pre_tick = src_tick && (pre_q == pre_last) && ctrl_q[sbtc_pkg::BIT_RUN];

  // prescaler cleared by low byte writes only
  always_ff @(posedge aclk)
  begin
    if (!aresetn || wr_low)
      pre_q <= 3'h0;
    else if (src_tick && ctrl_q[sbtc_pkg::BIT_RUN])
      pre_q <= (pre_q == pre_last) ? 3'h0 : pre_q + 3'h1;
  end

  // bus handshakes: address and data latch independently
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_ok = wr_fire && ws_q[0];
  assign wr_ctrl = wr_ok && (aw_q == sbtc_pkg::ADDR_CONTROL);
  assign wr_low = wr_ok && (aw_q == sbtc_pkg::ADDR_COUNT_LOW);
  assign wr_high = wr_ok && (aw_q == sbtc_pkg::ADDR_COUNT_HIGH);
  assign wr_flags = wr_ok && (aw_q == sbtc_pkg::ADDR_FLAGS);
  assign wr_port = wr_ok && (aw_q == sbtc_pkg::ADDR_PORT_C);
  assign rd_low = rd_fire && (s_axi_araddr == sbtc_pkg::ADDR_COUNT_LOW);

  // write address channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      aw_q <= 5'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
    end
  end

  // write data channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_have_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
    end
  end

  // write response; unmapped addresses answer with slave error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sbtc_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_q > sbtc_pkg::ADDR_PORT_C || aw_q[1:0] != 2'h0)
        ? sbtc_pkg::RESP_SLVERR : sbtc_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control register; bit 6 never stores
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= sbtc_pkg::CONTROL_RESET;
    else if (wr_ctrl)
      ctrl_q <= w_q[7:0] & sbtc_pkg::CONTROL_MASK;
  end

  assign cnt = {high_q, low_q};
  assign roll = pre_tick && (cnt == 16'hFFFF);

  // counter: software write first, then compare reset, then count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_q <= sbtc_pkg::COUNT_RESET[7:0];
      high_q <= sbtc_pkg::COUNT_RESET[15:8];
    end
    else if (wr_low || wr_high)
    begin
      // write wins over compare reset
      if (wr_low)
        low_q <= w_q[7:0];
      if (wr_low && ctrl_q[sbtc_pkg::BIT_WIDE])
        high_q <= hbuf_q;
      else if (wr_high && !ctrl_q[sbtc_pkg::BIT_WIDE])
        high_q <= w_q[7:0];
    end
    else if (compare_unit_reset)
    begin
      low_q <= 8'h00;
      high_q <= 8'h00;
    end
    else if (pre_tick)
      {high_q, low_q} <= cnt + 16'h0001;
  end

  // high byte buffer: loaded by high byte writes and by low byte reads in wide mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hbuf_q <= 8'h00;
    else if (wr_high && ctrl_q[sbtc_pkg::BIT_WIDE])
      hbuf_q <= w_q[7:0];
    else if (rd_low && ctrl_q[sbtc_pkg::BIT_WIDE])
      hbuf_q <= high_q;
  end

  // overflow flag: hardware set beats software clear; compare reset sets nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ovf_flag_q <= 1'b0;
    else if (roll)
      ovf_flag_q <= 1'b1;
    else if (wr_flags)
      ovf_flag_q <= w_q[sbtc_pkg::BIT_OVF];
  end

  // port direction bits for the two oscillator pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port_dir_q <= sbtc_pkg::PORT_DIR_RESET;
    else if (wr_port)
      port_dir_q <= w_q[1:0];
  end

  // pin and oscillator outputs; sleep never gates the oscillator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_en_q <= 1'b0;
      force_q <= 2'h0;
      ovf_q <= 1'b0;
    end
    else
    begin
      osc_en_q <= ctrl_q[sbtc_pkg::BIT_OSC_EN] | (sleep_mode & osc_en_q);
      force_q <= ctrl_q[sbtc_pkg::BIT_OSC_EN] ? 2'h3 : port_dir_q;
      ovf_q <= roll;
    end
  end
  assign osc_enable_out = osc_en_q;
  assign port_c_input_force = force_q;
  assign overflow_pulse = ovf_q;

  // read mux; high address reads buffer in wide mode
  always_comb
  begin
    unique case (s_axi_araddr)
      sbtc_pkg::ADDR_CONTROL: rd_byte = ctrl_q;
      sbtc_pkg::ADDR_COUNT_LOW: rd_byte = low_q;
      sbtc_pkg::ADDR_COUNT_HIGH: rd_byte = ctrl_q[sbtc_pkg::BIT_WIDE] ? hbuf_q : high_q;
      sbtc_pkg::ADDR_FLAGS: rd_byte = {7'h00, ovf_flag_q};
      sbtc_pkg::ADDR_PORT_C:
        rd_byte = {6'h00, ctrl_q[sbtc_pkg::BIT_OSC_EN] ? 2'h0 : port_c_pin_in};
      default: rd_byte = 8'h00;
    endcase
  end

  // read channel: one cycle latency, held until rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= sbtc_pkg::RESP_OKAY;
    end
    else
    begin
      // ready whenever no answer is pending; never waits on arvalid, so no deadlock
      s_axi_arready <= !s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= (s_axi_araddr > sbtc_pkg::ADDR_PORT_C || s_axi_araddr[1:0] != 2'h0)
          ? sbtc_pkg::RESP_SLVERR : sbtc_pkg::RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  property p_bit6_zero;
    @(posedge aclk) disable iff (!aresetn) ctrl_q[sbtc_pkg::BIT_UNUSED] == 1'b0;
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("bit 6 set");

  property p_roll_flag;
    @(posedge aclk) disable iff (!aresetn)
      roll && !wr_low && !wr_high |=> ovf_flag_q && ovf_q && cnt == 16'h0000;
  endproperty
  a_roll_flag: assert property (p_roll_flag) else $error("overflow lost");

  property p_stop;
    @(posedge aclk) disable iff (!aresetn)
      !ctrl_q[sbtc_pkg::BIT_RUN] && !wr_low && !wr_high && !compare_unit_reset |=> $stable(cnt);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");

  property p_cmp_reset;
    @(posedge aclk) disable iff (!aresetn) compare_unit_reset && !wr_low && !wr_high |=> cnt == 16'h0000;
  endproperty
  a_cmp_reset: assert property (p_cmp_reset) else $error("compare reset missed");

  property p_write_wins;
    @(posedge aclk) disable iff (!aresetn) wr_low && compare_unit_reset |=> low_q == $past(w_q[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to reset");

  property p_wide_load;
    @(posedge aclk) disable iff (!aresetn)
      wr_low && ctrl_q[sbtc_pkg::BIT_WIDE] |=> high_q == $past(hbuf_q);
  endproperty
  a_wide_load: assert property (p_wide_load) else $error("high byte not loaded");

  property p_latch_high;
    @(posedge aclk) disable iff (!aresetn)
      rd_low && ctrl_q[sbtc_pkg::BIT_WIDE] && !wr_high |=> hbuf_q == $past(high_q);
  endproperty
  a_latch_high: assert property (p_latch_high) else $error("buffer not latched");

  property p_timer_rate;
    @(posedge aclk) disable iff (!aresetn)
      mode == sbtc_pkg::SBTC_TIMER && pre_tick |=> !pre_tick [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer faster than sysclk/4");

  property p_pin_force;
    @(posedge aclk) disable iff (!aresetn) ctrl_q[sbtc_pkg::BIT_OSC_EN] |=> force_q == 2'h3;
  endproperty
  a_pin_force: assert property (p_pin_force) else $error("pins not forced");

  c_roll: cover property (@(posedge aclk) disable iff (!aresetn) roll);
  c_sync_tick: cover property (@(posedge aclk) disable iff (!aresetn)
    mode == sbtc_pkg::SBTC_SYNC_CNT && pre_tick);
  c_clash: cover property (@(posedge aclk) disable iff (!aresetn) wr_low && compare_unit_reset);
endmodule

/* File: logic/sbtc_pkg.sv */
package sbtc_pkg;
  // byte addresses of the register words (layout chosen for the bus)
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_COUNT_LOW = 5'h04;
  localparam logic [4:0] ADDR_COUNT_HIGH = 5'h08;
  localparam logic [4:0] ADDR_FLAGS = 5'h0C;
  localparam logic [4:0] ADDR_PORT_C = 5'h10;
  // control and flags field positions
  localparam int BIT_WIDE = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_DIV_HI = 5;
  localparam int BIT_DIV_LO = 4;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_SYNC_BYP = 2;
  localparam int BIT_CLK_SEL = 1;
  localparam int BIT_RUN = 0;
  localparam int BIT_OVF = 0;
  // values after reset, and the control write mask
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_MASK = 8'hBF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] PORT_DIR_RESET = 2'h3;
  // internal clock is the system clock divided by four
  localparam logic [1:0] INT_DIV_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SBTC_TIMER, SBTC_SYNC_CNT, SBTC_ASYNC_CNT} sbtc_mode_e;
endpackage

/* File: logic/sbtc_edge_sync.sv */
`timescale 1ns/1ps
// two-flop synchronizer plus rising edge detector for the external count input
module sbtc_edge_sync
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic raw_in,
  output logic rise
);
  logic meta_q; // first stage, read only by second stage
  logic sync_q; // second stage
  logic last_q; // previous synchronised level

  // synchroniser chain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // edge taken only from the settled stages
  assign rise = sync_q & ~last_q;
endmodule

/* File: tb/sbtc_clk_src.sv */
`timescale 1ns/1ps
// far-side clock source: external count pin or crystal, both idle low between bursts
module sbtc_clk_src
(
  input wire logic aclk,
  output logic ext_pin,
  output logic osc_pin
);
  // lines rest low outside a burst, so no stray edge reaches the counter
  initial
  begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end
  // n rising edges, each level held half aclk cycles; three or more keeps the synchroniser fed
  task automatic burst(input bit use_osc, input int n, input int half);
    for (int i = 0; i < 2 * n; i++)
    begin
      @(posedge aclk);
      // crystal output or external pin, never both
      if (use_osc)
        osc_pin <= ~osc_pin;
      else
        ext_pin <= ~ext_pin;
      repeat (half - 1) @(posedge aclk);
    end
  endtask
endmodule

/* File: tb/sbtc_top_tb.sv */
`timescale 1ns/1ps
// self-checking bench: axi-lite master, clock source model, timer scenarios
module sbtc_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cmp_rst = 1'b0;
  logic sleep = 1'b0;
  logic [1:0] pins = 2'h2;
  // design outputs and clock source pins
  logic awready, wready, bvalid, arready, rvalid, osc_en, ovf, ext_pin, osc_pin;
  logic [1:0] bresp, rresp, force_in, rr, br;
  logic [31:0] rdata, rd_val;
  logic [7:0] hb, lb;
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'h8583A507;
  int n, ps, cnt;
  // 100 MHz system clock
  always #5 aclk = ~aclk;
  sbtc_top sbtc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_count_clock_pin(ext_pin),
    .osc_in_pin(osc_pin), .port_c_pin_in(pins), .compare_unit_reset(cmp_rst),
    .sleep_mode(sleep), .osc_enable_out(osc_en), .port_c_input_force(force_in),
    .overflow_pulse(ovf));
  sbtc_clk_src sbtc_clk_src_i (.aclk(aclk), .ext_pin(ext_pin), .osc_pin(osc_pin));
  // one comparison, counted; mismatch reported at once
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a wait that runs past its bound counts as a mismatch and closes the run
  task automatic guard(input int k);
    if (k > 300)
    begin
      err_total++;
      final_report();
    end
  endtask
  // axi-lite write; cmp raises the compare reset on the edge that applies the write
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input bit cmp = 1'b0);
    int k;
    bit a_p, w_p, b_p, t;
    k = 0;
    a_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b_p)
    begin
      @(posedge aclk);
      k++;
      guard(k);
      t = a_p || w_p;
      // each channel released at its own handshake
      if (a_p && awready === 1'b1)
      begin
        a_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1)
      begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
      // both taken now: the write lands on the next edge, so the clash lands with it
      cmp_rst <= cmp && t && !a_p && !w_p;
      if (bvalid === 1'b1)
      begin
        b_p = 1'b0;
        br = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  // axi-lite read; data and response taken at the rvalid edge
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    bit a_p, r_p;
    k = 0;
    a_p = 1'b1;
    r_p = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r_p)
    begin
      @(posedge aclk);
      k++;
      guard(k);
      if (a_p && arready === 1'b1)
      begin
        a_p = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1)
      begin
        r_p = 1'b0;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  // read and compare in one call
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    rd_reg(a, rd_val, rr);
    check(rd_val, exp);
  endtask
  // high byte first so wide mode loads both at the low write
  task automatic set_count(input logic [7:0] h, input logic [7:0] l);
    wr(sbtc_pkg::ADDR_COUNT_HIGH, {24'h0, h});
    wr(sbtc_pkg::ADDR_COUNT_LOW, {24'h0, l});
  endtask
  // main sequence
  initial
  begin
    pins <= 2'($random(seed));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk(sbtc_pkg::ADDR_CONTROL, 32'h0);
    rd_chk(sbtc_pkg::ADDR_COUNT_LOW, 32'h0);
    rd_chk(sbtc_pkg::ADDR_FLAGS, 32'h0);
    // unmapped word answers with an error and zero data
    rd_reg(5'h14, rd_val, rr);
    check(rr, sbtc_pkg::RESP_SLVERR);
    check(rd_val, 32'h0);
    wr(5'h14, 32'h0);
    check(br, sbtc_pkg::RESP_SLVERR);
    wr(sbtc_pkg::ADDR_CONTROL, 32'hFF);
    check(br, sbtc_pkg::RESP_OKAY);
    rd_chk(sbtc_pkg::ADDR_CONTROL, 32'hBF);
    check(osc_en, 32'h1);
    check(force_in, 32'h3);
    rd_chk(sbtc_pkg::ADDR_PORT_C, 32'h0);
    wr(sbtc_pkg::ADDR_CONTROL, 32'h0);
    wr(sbtc_pkg::ADDR_PORT_C, 32'h1);
    rd_chk(sbtc_pkg::ADDR_PORT_C, {30'h0, pins});
    check(osc_en, 32'h0);
    check(force_in, 32'h1);
    // low strobe clear: write dropped but still answered
    wstrb <= 4'hE;
    wr(sbtc_pkg::ADDR_CONTROL, 32'h1);
    wstrb <= 4'hF;
    rd_chk(sbtc_pkg::ADDR_CONTROL, 32'h0);
    $display("registers done");
    // timer mode over every prescale; bypass bit set at random must not matter
    for (ps = 0; ps < 4; ps++)
    begin
      set_count(8'h00, 8'h00);
      wr(sbtc_pkg::ADDR_CONTROL, (ps << 4) | 1 | ($random(seed) & 4));
      repeat (64 << ps) @(posedge aclk);
      wr(sbtc_pkg::ADDR_CONTROL, 32'h0);
      rd_reg(sbtc_pkg::ADDR_COUNT_LOW, rd_val, rr);
      // bus latency at start and stop leaves one tick of slack
      check(rd_val >= 15 && rd_val <= 17, 32'h1);
      repeat (40) @(posedge aclk);
      rd_chk(sbtc_pkg::ADDR_COUNT_LOW, rd_val);
      $display("timer prescale %0d done", 1 << ps);
    end
    // synced pin, raw pin, crystal; random prescale, burst length and sleep
    for (int m = 0; m < 3; m++)
    begin
      ps = $random(seed) & 3;
      n = 8 + ($random(seed) & 15);
      sleep <= 1'($random(seed));
      set_count(8'h00, 8'h00);
      wr(sbtc_pkg::ADDR_CONTROL, (ps << 4) | 3 | (m == 1 ? 4 : 0) | (m == 2 ? 8 : 0));
      repeat (20) @(posedge aclk); // crystal start-up delay before counting
      sbtc_clk_src_i.burst(m == 2, n, 3);
      repeat (8) @(posedge aclk);
      rd_chk(sbtc_pkg::ADDR_COUNT_LOW, n >> ps);
      check(osc_en, m == 2);
      $display("external mode %0d done", m);
    end
    sleep <= 1'b0;
    // rollover from all ones
    set_count(8'hFF, 8'hF8);
    wr(sbtc_pkg::ADDR_CONTROL, 32'h1);
    n = 0;
    cnt = 0;
    while (n < 200 && cnt == 0)
    begin
      @(posedge aclk);
      n++;
      if (ovf === 1'b1)
        cnt++;
    end
    if (n == 200)
      guard(999);
    check(cnt, 32'h1);
    wr(sbtc_pkg::ADDR_CONTROL, 32'h0);
    rd_chk(sbtc_pkg::ADDR_FLAGS, 32'h1);
    rd_chk(sbtc_pkg::ADDR_COUNT_HIGH, 32'h0);
    wr(sbtc_pkg::ADDR_FLAGS, 32'h0);
    rd_chk(sbtc_pkg::ADDR_FLAGS, 32'h0);
    $display("overflow done");
    // byte mode writes land directly; wide mode goes through the buffer
    hb = 8'($random(seed));
    lb = 8'($random(seed));
    wr(sbtc_pkg::ADDR_COUNT_HIGH, 32'hAB);
    rd_chk(sbtc_pkg::ADDR_COUNT_HIGH, 32'hAB);
    wr(sbtc_pkg::ADDR_CONTROL, 32'h80);
    set_count(hb, lb);
    rd_chk(sbtc_pkg::ADDR_COUNT_LOW, lb);
    wr(sbtc_pkg::ADDR_COUNT_HIGH, ~hb);
    rd_chk(sbtc_pkg::ADDR_COUNT_HIGH, {24'h0, ~hb});
    rd_chk(sbtc_pkg::ADDR_COUNT_LOW, lb);
    rd_chk(sbtc_pkg::ADDR_COUNT_HIGH, hb);
    $display("wide access done");
    // compare reset clears; a write on the same edge wins
    wr(sbtc_pkg::ADDR_CONTROL, 32'h0);
    @(posedge aclk);
    cmp_rst <= 1'b1;
    @(posedge aclk);
    cmp_rst <= 1'b0;
    rd_chk(sbtc_pkg::ADDR_COUNT_LOW, 32'h0);
    rd_chk(sbtc_pkg::ADDR_COUNT_HIGH, 32'h0);
    // odd value, so a reset that wins would show as zero
    wr(sbtc_pkg::ADDR_COUNT_LOW, {24'h0, lb | 8'h01}, 1'b1);
    rd_chk(sbtc_pkg::ADDR_COUNT_LOW, {24'h0, lb | 8'h01});
    $display("compare reset done");
    final_report();
  end
endmodule
